// *** conv_clock_divider_sel_pkg.sv ***
// Constants and register map of the converter sequencer control block
package conv_clock_divider_sel_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_RESULT_HIGH = 8'h1e;
  localparam logic [7:0] IDX_CONV_CTRL = 8'h1f;
  localparam logic [7:0] IDX_PIN_SELECT = 8'h91;
  localparam logic [7:0] IDX_RESULT_LOW = 8'h9e;
  localparam logic [7:0] IDX_CLK_SELECT = 8'h9f;
  localparam int ADDR_W = 10;
  // Reset values
  localparam logic [7:0] RST_CONV_CTRL = 8'h00;
  localparam logic [7:0] RST_PIN_SELECT = 8'hff;
  localparam logic [2:0] RST_CLK_SEL = 3'h0;
  // Control register fields
  localparam int CTRL_JUSTIFY = 7;
  localparam int CTRL_VREF = 6;
  localparam int CTRL_CHS_LSB = 2;
  localparam int CTRL_GO = 1;
  localparam int CTRL_ON = 0;
  localparam int CTRL_RSVD = 5;
  // Clock select field position
  localparam int CSEL_LSB = 4;
  // Conversion clock select codes
  localparam logic [2:0] SEL_DIV2 = 3'h0;
  localparam logic [2:0] SEL_DIV4 = 3'h4;
  localparam logic [2:0] SEL_DIV8 = 3'h1;
  localparam logic [2:0] SEL_DIV16 = 3'h5;
  localparam logic [2:0] SEL_DIV32 = 3'h2;
  localparam logic [2:0] SEL_DIV64 = 3'h6;
  localparam logic [1:0] SEL_RC_LOW = 2'h3;
  // System clocks per conversion bit period for each divide code
  localparam logic [7:0] DIV2_CLKS = 8'h02;
  localparam logic [7:0] DIV4_CLKS = 8'h04;
  localparam logic [7:0] DIV8_CLKS = 8'h08;
  localparam logic [7:0] DIV16_CLKS = 8'h10;
  localparam logic [7:0] DIV32_CLKS = 8'h20;
  localparam logic [7:0] DIV64_CLKS = 8'h40;
  // Timing
  localparam int CLK_FREQ_KHZ = 100000;
  localparam int RC_FREQ_MAX_KHZ = 500;
  localparam int RC_DIV_INT = (CLK_FREQ_KHZ + RC_FREQ_MAX_KHZ - 1) / RC_FREQ_MAX_KHZ;
  localparam logic [7:0] RC_DIV = 8'(RC_DIV_INT);
  localparam logic [7:0] INSTR_CLKS = 8'h04;
  localparam logic [3:0] CONV_BIT_PERIODS = 4'hb;
  localparam logic [3:0] ABORT_BIT_PERIODS = 4'h2;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_START_WAIT = 2'b01,
    ST_CONVERT = 2'b10,
    ST_ABORT_WAIT = 2'b11
  } conv_clock_divider_sel_state_type;
endpackage

// *** conv_clock_divider_sel_ctrl.sv ***
// Converter sequencer control: registers, clock select, sequencing, sleep
//
// Chosen here: register access over Avalon-MM.
`timescale 1ns/1ps
// Notes on behaviour
// R1 - Three select bits pick system clock divide 2..64 or internal RC clock.
// R2 - RC option clocks conversion from a dedicated oscillator at most 500 kHz.
// R3 - Eight analog-select bits, set means analog pin; all reset to one.
// R4 - Analog pin disables its digital input, weak pull-up and change interrupt.
// R5 - Software sets the pin direction of an analog pin to input.
// R6 - Software waits the acquisition time after a channel change before starting.
// R7 - Software selects the RC clock for conversions that run during sleep.
// R8 - With RC clock, conversion starts one instruction cycle after the trigger.
// R9 - On completion go bit clears and the 10-bit result is loaded.
// R10 - Completion in sleep with interrupt enabled wakes the device.
// R11 - Completion in sleep with interrupt disabled powers converter down, on-bit kept.
// R12 - Sleep with non-RC clock aborts conversion, powers down, on-bit kept.
// R13 - Reset restores registers, turns converter off, aborts pending conversion.
// R14 - Reset leaves result registers unchanged; unknown after power-on.
// R15 - A conversion takes eleven conversion clock periods.
// R16 - Go bit starts; completion clears go, flags done, interrupts if enabled.
// R17 - Software abort keeps old result; acquisition restarts after two periods.
// R18 - Justify bit set gives right justified result, clear gives left.
// R19 - Left: high holds top eight, low top holds two; right is reverse.
// R20 - Clock select register bit 7 and bits 3..0 read as zero.
module conv_clock_divider_sel_ctrl (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [9:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic sleep_i,
  input wire logic conversion_done_irq_enable_i,
  input wire logic [9:0] conv_result_i,
  input wire logic [7:0] pin_digital_in_i,
  input wire logic [7:0] pin_pullup_en_i,
  input wire logic [7:0] pin_ioc_en_i,
  output logic [7:0] pin_digital_in_o,
  output logic [7:0] pin_pullup_en_o,
  output logic [7:0] pin_ioc_en_o,
  output logic [7:0] pin_analog_enable_o,
  output logic [2:0] input_channel_sel_o,
  output logic vref_sel_o,
  output logic converter_active_o,
  output logic acquire_o,
  output logic bit_period_tick_o,
  output logic conversion_done_flag_o,
  output logic wake_o
);
  logic [7:0] ctrl_r;
  logic [7:0] analog_pin_select_r;
  logic [2:0] csel_r;
  logic [7:0] res_high_r;
  logic [7:0] res_low_r;
  logic [31:0] rdata_r;
  logic ack_r;
  logic powered_down_r;
  logic done_r;
  logic wake_r;
  conv_clock_divider_sel_pkg::conv_clock_divider_sel_state_type state_r;
  conv_clock_divider_sel_pkg::conv_clock_divider_sel_state_type state_nxt;
  logic [7:0] div_cnt_r;
  logic [7:0] div_limit;
  logic [7:0] wait_cnt_r;
  logic [3:0] tad_cnt_r;
  logic tad_tick;
  logic rc_sel;
  logic req;
  logic wr_en;
  logic [7:0] idx;
  logic ctrl_wr;
  logic go_wr_set;
  logic go_wr_clr;
  logic finish;
  logic sleep_abort;
  logic sw_abort;
  logic running;

  assign idx = avs_address_i[conv_clock_divider_sel_pkg::ADDR_W-1:2];
  assign req = avs_read_i | avs_write_i;
  // One wait state: the read word is ready at the releasing edge
  assign avs_waitrequest_o = req & ~ack_r;
  assign wr_en = avs_write_i & ack_r;
  assign ctrl_wr = wr_en & (idx == conv_clock_divider_sel_pkg::IDX_CONV_CTRL);
  assign go_wr_set = ctrl_wr & avs_writedata_i[conv_clock_divider_sel_pkg::CTRL_GO];
  assign go_wr_clr = ctrl_wr & ~avs_writedata_i[conv_clock_divider_sel_pkg::CTRL_GO];
  assign rc_sel = (csel_r[1:0] == conv_clock_divider_sel_pkg::SEL_RC_LOW); // R1

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      ack_r <= 1'b0;
    else
      ack_r <= req & ~ack_r;
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      rdata_r <= 32'h0000_0000;
    else if (avs_read_i && !ack_r)
    begin
      unique case (idx)
        conv_clock_divider_sel_pkg::IDX_RESULT_HIGH: rdata_r <= {24'h00_0000, res_high_r};
        conv_clock_divider_sel_pkg::IDX_CONV_CTRL: rdata_r <= {24'h00_0000, ctrl_r};
        conv_clock_divider_sel_pkg::IDX_PIN_SELECT: rdata_r <= {24'h00_0000, analog_pin_select_r};
        conv_clock_divider_sel_pkg::IDX_RESULT_LOW: rdata_r <= {24'h00_0000, res_low_r};
        conv_clock_divider_sel_pkg::IDX_CLK_SELECT: rdata_r <= {25'h000_0000, csel_r, 4'h0}; // R20
        default: rdata_r <= 32'h0000_0000;
      endcase
    end
  end
  assign avs_readdata_o = rdata_r;

  // Divisor for the selected conversion clock
  always_comb
  begin
    div_limit = conv_clock_divider_sel_pkg::RC_DIV; // R2
    if (!rc_sel)
    begin
      unique case (csel_r)
        conv_clock_divider_sel_pkg::SEL_DIV2: div_limit = conv_clock_divider_sel_pkg::DIV2_CLKS; // R1
        conv_clock_divider_sel_pkg::SEL_DIV4: div_limit = conv_clock_divider_sel_pkg::DIV4_CLKS;
        conv_clock_divider_sel_pkg::SEL_DIV8: div_limit = conv_clock_divider_sel_pkg::DIV8_CLKS;
        conv_clock_divider_sel_pkg::SEL_DIV16: div_limit = conv_clock_divider_sel_pkg::DIV16_CLKS;
        conv_clock_divider_sel_pkg::SEL_DIV32: div_limit = conv_clock_divider_sel_pkg::DIV32_CLKS;
        conv_clock_divider_sel_pkg::SEL_DIV64: div_limit = conv_clock_divider_sel_pkg::DIV64_CLKS;
        default: div_limit = conv_clock_divider_sel_pkg::RC_DIV;
      endcase
    end
  end

  assign running = (state_r == conv_clock_divider_sel_pkg::ST_CONVERT) || (state_r == conv_clock_divider_sel_pkg::ST_ABORT_WAIT);

  // Divider restarts with each conversion so the first period is whole
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      div_cnt_r <= 8'h00;
    else if (!running || div_cnt_r == div_limit - 8'h01)
      div_cnt_r <= 8'h00;
    else
      div_cnt_r <= div_cnt_r + 8'h01;
  end
  assign tad_tick = running && (div_cnt_r == div_limit - 8'h01);
  assign bit_period_tick_o = tad_tick;

  assign finish = (state_r == conv_clock_divider_sel_pkg::ST_CONVERT) && tad_tick
    && (tad_cnt_r == conv_clock_divider_sel_pkg::CONV_BIT_PERIODS - 4'h1); // R15
  // Non-RC clock cannot keep running while the core is asleep
  assign sleep_abort = sleep_i && !rc_sel && (state_r != conv_clock_divider_sel_pkg::ST_IDLE); // R12
  assign sw_abort = go_wr_clr && (state_r == conv_clock_divider_sel_pkg::ST_CONVERT); // R17

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      conv_clock_divider_sel_pkg::ST_IDLE:
        if (go_wr_set && ctrl_r[conv_clock_divider_sel_pkg::CTRL_ON] && avs_writedata_i[conv_clock_divider_sel_pkg::CTRL_ON]
          && !sleep_abort)
          state_nxt = rc_sel ? conv_clock_divider_sel_pkg::ST_START_WAIT : conv_clock_divider_sel_pkg::ST_CONVERT; // R8 R16
      conv_clock_divider_sel_pkg::ST_START_WAIT:
        if (go_wr_clr)
          state_nxt = conv_clock_divider_sel_pkg::ST_IDLE;
        else if (wait_cnt_r == conv_clock_divider_sel_pkg::INSTR_CLKS - 8'h01)
          state_nxt = conv_clock_divider_sel_pkg::ST_CONVERT; // R8
      conv_clock_divider_sel_pkg::ST_CONVERT:
        if (sw_abort)
          state_nxt = conv_clock_divider_sel_pkg::ST_ABORT_WAIT; // R17
        else if (finish)
          state_nxt = conv_clock_divider_sel_pkg::ST_IDLE;
      conv_clock_divider_sel_pkg::ST_ABORT_WAIT:
        if (tad_tick && tad_cnt_r == conv_clock_divider_sel_pkg::ABORT_BIT_PERIODS - 4'h1)
          state_nxt = conv_clock_divider_sel_pkg::ST_IDLE; // R17
    endcase
    if (sleep_abort || !ctrl_r[conv_clock_divider_sel_pkg::CTRL_ON])
      state_nxt = conv_clock_divider_sel_pkg::ST_IDLE;
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      state_r <= conv_clock_divider_sel_pkg::ST_IDLE; // R13
    else
      state_r <= state_nxt;
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      wait_cnt_r <= 8'h00;
    else if (state_r == conv_clock_divider_sel_pkg::ST_START_WAIT)
      wait_cnt_r <= wait_cnt_r + 8'h01;
    else
      wait_cnt_r <= 8'h00;
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      tad_cnt_r <= 4'h0;
    else if (state_nxt != state_r)
      tad_cnt_r <= 4'h0;
    else if (tad_tick)
      tad_cnt_r <= tad_cnt_r + 4'h1;
  end

  // Control register; hardware clear of go wins over a fresh set in the same cycle
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      ctrl_r <= conv_clock_divider_sel_pkg::RST_CONV_CTRL; // R13
    else
    begin
      if (ctrl_wr)
      begin
        ctrl_r <= avs_writedata_i[7:0];
        ctrl_r[conv_clock_divider_sel_pkg::CTRL_RSVD] <= 1'b0;
        // Go may only rise when the converter was already on
        ctrl_r[conv_clock_divider_sel_pkg::CTRL_GO] <= go_wr_set && ctrl_r[conv_clock_divider_sel_pkg::CTRL_ON]
          && avs_writedata_i[conv_clock_divider_sel_pkg::CTRL_ON] && !sleep_abort
          && !finish && (state_r != conv_clock_divider_sel_pkg::ST_ABORT_WAIT);
      end
      else if (finish || sleep_abort) // R9 R12
        ctrl_r[conv_clock_divider_sel_pkg::CTRL_GO] <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      analog_pin_select_r <= conv_clock_divider_sel_pkg::RST_PIN_SELECT; // R3
    else if (wr_en && idx == conv_clock_divider_sel_pkg::IDX_PIN_SELECT)
      analog_pin_select_r <= avs_writedata_i[7:0];
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      csel_r <= conv_clock_divider_sel_pkg::RST_CLK_SEL;
    else if (wr_en && idx == conv_clock_divider_sel_pkg::IDX_CLK_SELECT)
      csel_r <= avs_writedata_i[conv_clock_divider_sel_pkg::CSEL_LSB +: 3];
  end

  // No reset: results survive a device reset
  always_ff @(posedge clk_i) // R14
  begin
    if (finish) // R9
    begin
      if (ctrl_r[conv_clock_divider_sel_pkg::CTRL_JUSTIFY]) // R18
      begin
        res_high_r <= {6'h00, conv_result_i[9:8]}; // R19
        res_low_r <= conv_result_i[7:0];
      end
      else
      begin
        res_high_r <= conv_result_i[9:2]; // R19
        res_low_r <= {conv_result_i[1:0], 6'h00};
      end
    end
  end

  // Analog power drops in sleep with a non-RC clock or when an RC conversion completes with interrupt off; on-bit stays set
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      powered_down_r <= 1'b0;
    else if (!sleep_i)
      powered_down_r <= 1'b0;
    else if (sleep_abort) // R12
      powered_down_r <= 1'b1;
    else if (finish && !conversion_done_irq_enable_i) // R11
      powered_down_r <= 1'b1;
    else if (!running && state_r == conv_clock_divider_sel_pkg::ST_IDLE && !rc_sel)
      powered_down_r <= 1'b1;
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      done_r <= 1'b0;
      wake_r <= 1'b0;
    end
    else
    begin
      done_r <= finish; // R16
      wake_r <= finish && sleep_i && conversion_done_irq_enable_i; // R10
    end
  end

  assign conversion_done_flag_o = done_r;
  assign wake_o = wake_r;
  assign converter_active_o = ctrl_r[conv_clock_divider_sel_pkg::CTRL_ON] && !powered_down_r;
  // Sample switch closed only in idle and start wait, so acquisition restarts on its own after the abort wait
  assign acquire_o = converter_active_o && (state_r == conv_clock_divider_sel_pkg::ST_IDLE
    || state_r == conv_clock_divider_sel_pkg::ST_START_WAIT); // R17
  assign input_channel_sel_o = ctrl_r[conv_clock_divider_sel_pkg::CTRL_CHS_LSB +: 3];
  assign vref_sel_o = ctrl_r[conv_clock_divider_sel_pkg::CTRL_VREF];
  assign pin_analog_enable_o = analog_pin_select_r; // R3
  // Analog pins see no digital input, pull-up or change interrupt
  assign pin_digital_in_o = pin_digital_in_i & ~analog_pin_select_r; // R4
  assign pin_pullup_en_o = pin_pullup_en_i & ~analog_pin_select_r; // R4
  assign pin_ioc_en_o = pin_ioc_en_i & ~analog_pin_select_r; // R4
endmodule // conv_clock_divider_sel_ctrl

// *** conv_clock_divider_sel_far_model.sv ***
// Analog core stand-in that feeds the converter result input
`timescale 1ns/1ps
module conv_clock_divider_sel_far_model (
  input wire logic acquire_i,
  // Pin driver stays off, so only the outside source sets the level
  input wire logic [9:0] value_i,
  output logic [9:0] conv_result_o
);
  // Inverts the pin while sampling, so a capture then reads wrong
  assign conv_result_o = acquire_i ? ~value_i : value_i;
endmodule // conv_clock_divider_sel_far_model

// *** conv_clock_divider_sel_ctrl_sva.sv ***
// Checker of bus timing, pin masking and conversion pulses
`timescale 1ns/1ps
module conv_clock_divider_sel_ctrl_sva (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input wire logic sleep_i,
  input wire logic conversion_done_irq_enable_i,
  input wire logic [7:0] pin_digital_in_i,
  input wire logic [7:0] pin_digital_in_o,
  input wire logic [7:0] pin_analog_enable_o,
  input wire logic converter_active_o,
  input wire logic acquire_o,
  input wire logic bit_period_tick_o,
  input wire logic conversion_done_flag_o,
  input wire logic wake_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  bus_wait_a: assert property ($rose(avs_read_i || avs_write_i) |->
    avs_waitrequest_o ##1 !avs_waitrequest_o) else $error("bad wait state");
  din_mask_a: assert property (pin_digital_in_o == (pin_digital_in_i & ~pin_analog_enable_o))
    else $error("digital path not masked");
  wake_pair_a: assert property (wake_o |-> conversion_done_flag_o && $past(sleep_i)
    && $past(conversion_done_irq_enable_i)) else $error("wake without cause");
  done_pulse_a: assert property (conversion_done_flag_o |=> !conversion_done_flag_o)
    else $error("done not a pulse");
  tick_gap_a: assert property (bit_period_tick_o |=> !bit_period_tick_o)
    else $error("period shorter than two clocks");
  acq_on_a: assert property (conversion_done_flag_o |-> acquire_o == converter_active_o)
    else $error("sampling not restarted");
  done_idle_a: assert property (conversion_done_flag_o |-> !bit_period_tick_o)
    else $error("tick after completion");
  acq_tick_a: assert property (acquire_o |-> !bit_period_tick_o)
    else $error("tick while sampling");
  done_c: cover property (conversion_done_flag_o);
  wake_c: cover property (wake_o);
  acq_c: cover property ($fell(acquire_o));
endmodule // conv_clock_divider_sel_ctrl_sva
bind conv_clock_divider_sel_ctrl conv_clock_divider_sel_ctrl_sva chk (.clk_i, .arst_n_i, .avs_read_i, .avs_write_i,
  .avs_waitrequest_o, .sleep_i, .conversion_done_irq_enable_i, .pin_digital_in_i,
  .pin_digital_in_o, .pin_analog_enable_o, .converter_active_o, .acquire_o,
  .bit_period_tick_o, .conversion_done_flag_o, .wake_o);

// *** tb_top.sv ***
// Register-level test bench of the converter sequencer control
`timescale 1ns/1ps
module tb_top;
  localparam logic [9:0] A_RH = {conv_clock_divider_sel_pkg::IDX_RESULT_HIGH, 2'b00};
  localparam logic [9:0] A_CT = {conv_clock_divider_sel_pkg::IDX_CONV_CTRL, 2'b00};
  localparam logic [9:0] A_PS = {conv_clock_divider_sel_pkg::IDX_PIN_SELECT, 2'b00};
  localparam logic [9:0] A_RL = {conv_clock_divider_sel_pkg::IDX_RESULT_LOW, 2'b00};
  localparam logic [9:0] A_CS = {conv_clock_divider_sel_pkg::IDX_CLK_SELECT, 2'b00};
  logic clk_i = 1'b0, arst_n_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0;
  logic sleep_i = 1'b0, conversion_done_irq_enable_i = 1'b0;
  logic [9:0] avs_address_i = 10'h0, val = 10'h0, conv_result_i;
  logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, rdata;
  logic [7:0] pin_digital_in_i = 8'ha5, pin_pullup_en_i = 8'hff, pin_ioc_en_i = 8'h3c;
  logic [7:0] pin_digital_in_o, pin_analog_enable_o, ehi, elo, pin_pullup_en_o, pin_ioc_en_o;
  logic [2:0] input_channel_sel_o;
  logic vref_sel_o;
  logic [2:0] cd [7] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h7};
  int dv [7] = '{2, 4, 8, 16, 32, 64, 200};
  logic avs_waitrequest_o, converter_active_o, acquire_o, conversion_done_flag_o, wake_o;
  int bad_count = 0, cmp_count = 0, cyc = 0, cnt;
  conv_clock_divider_sel_ctrl uut (.clk_i, .arst_n_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .sleep_i,
    .conversion_done_irq_enable_i, .conv_result_i, .pin_digital_in_i, .pin_pullup_en_i,
    .pin_ioc_en_i, .pin_digital_in_o, .pin_pullup_en_o, .pin_ioc_en_o,
    .pin_analog_enable_o, .input_channel_sel_o, .vref_sel_o, .converter_active_o,
    .acquire_o, .bit_period_tick_o(), .conversion_done_flag_o, .wake_o);
  conv_clock_divider_sel_far_model far (.acquire_i(acquire_o), .value_i(val), .conv_result_o(conv_result_i));
  always #5 clk_i = ~clk_i;
  task report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      report_and_stop();
    end
  end
  task chk(input logic [31:0] s, input logic [31:0] e, input string n);
    cmp_count++;
    if (s !== e)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  // Request held until the edge that samples waitrequest low
  task wr(input logic [9:0] a, input logic [7:0] d);
    avs_address_i <= a;
    avs_writedata_i <= {24'h0, d};
    avs_write_i <= 1'b1;
    @(posedge clk_i iff avs_waitrequest_o === 1'b0);
    avs_write_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task rc(input logic [9:0] a, input logic [31:0] e, input string n);
    avs_address_i <= a;
    avs_read_i <= 1'b1;
    @(posedge clk_i iff avs_waitrequest_o === 1'b0);
    rdata = avs_readdata_o;
    avs_read_i <= 1'b0;
    @(posedge clk_i);
    chk(rdata, e, n);
  endtask
  task regs0();
    rc(A_CT, 32'h0, "ctrl");
    rc(A_CS, 32'h0, "clk sel");
    rc(A_PS, 32'hff, "pin sel");
    rc(10'h0, 32'h0, "unmapped");
  endtask
  task conv(input logic [2:0] c, input int e, input logic j, input logic s);
    wr(A_CS, {1'b0, c, 4'h0});
    wr(A_CT, {j, 7'h01});
    wr(A_CT, {j, 7'h03});
    sleep_i <= s;
    cnt = 0;
    while (conversion_done_flag_o !== 1'b1 && cnt < 3000)
    begin
      @(posedge clk_i);
      cnt++;
    end
    chk({31'h0, wake_o}, {31'h0, s & conversion_done_irq_enable_i}, "wake");
    chk({31'h0, cnt >= e - 1 && cnt <= e + 3}, 32'h1, "conv time");
    if (s && !conversion_done_irq_enable_i)
      chk({31'h0, converter_active_o}, 32'h0, "power down");
    ehi = j ? {6'h0, val[9:8]} : val[9:2];
    elo = j ? val[7:0] : {val[1:0], 6'h0};
    rc(A_RH, {24'h0, ehi}, "high");
    rc(A_RL, {24'h0, elo}, "low");
    rc(A_CT, {24'h0, j, 7'h01}, "go clear");
    sleep_i <= 1'b0;
  endtask
  initial
  begin
    repeat (20) @(posedge clk_i);
    arst_n_i <= 1'b1;
    @(posedge clk_i);
    regs0();
    wr(A_CS, 8'hff);
    rc(A_CS, 32'h70, "clk sel");
    wr(A_PS, 8'h0f);
    rc(A_PS, 32'h0f, "pin sel");
    chk({24'h0, pin_digital_in_o}, 32'ha0, "din");
    chk({24'h0, pin_pullup_en_o}, 32'hf0, "pullup");
    chk({24'h0, pin_ioc_en_o}, 32'h30, "ioc");
    chk({24'h0, pin_analog_enable_o}, 32'h0f, "analog en");
    wr(A_CT, 8'h7c);
    chk({29'h0, input_channel_sel_o}, 32'h7, "channel");
    chk({31'h0, vref_sel_o}, 32'h1, "vref");
    $display("test registers done");
    for (int i = 0; i < 7; i++)
    begin
      val <= 10'h2a7 + 10'(i * 37);
      conv(cd[i], 11 * dv[i] + (i == 6 ? 4 : 0), i[0], 1'b0);
    end
    $display("test dividers done");
    conversion_done_irq_enable_i <= 1'b1;
    conv(3'h3, 2204, 1'b1, 1'b1);
    conversion_done_irq_enable_i <= 1'b0;
    conv(3'h7, 2204, 1'b0, 1'b1);
    $display("test sleep done");
    val <= 10'h155;
    wr(A_CS, 8'h60);
    wr(A_CT, 8'h03);
    repeat (50) @(posedge clk_i);
    wr(A_CT, 8'h01);
    chk({31'h0, acquire_o}, 32'h0, "abort wait");
    repeat (140) @(posedge clk_i);
    chk({31'h0, acquire_o}, 32'h1, "reacquire");
    rc(A_RH, {24'h0, ehi}, "kept");
    wr(A_CT, 8'h03);
    sleep_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    rc(A_CT, 32'h01, "sleep abort");
    chk({31'h0, converter_active_o}, 32'h0, "sleep off");
    sleep_i <= 1'b0;
    $display("test abort done");
    wr(A_CT, 8'h5f);
    repeat (30) @(posedge clk_i);
    arst_n_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    arst_n_i <= 1'b1;
    @(posedge clk_i);
    regs0();
    chk({31'h0, converter_active_o}, 32'h0, "off");
    chk({28'h0, vref_sel_o, input_channel_sel_o}, 32'h0, "ctrl outs");
    rc(A_RH, {24'h0, ehi}, "res kept");
    $display("test reset done");
    report_and_stop();
  end
endmodule // tb_top
